// ==== rtl/capture_consts.svh ====
`ifndef CAPTURE_CONSTS_SVH
`define CAPTURE_CONSTS_SVH

`define NCH            2
`define SAMPLE_W       14
`define SUM_W          32
`define HIST_AW        6
`define SPAN_W         7
`define BASE_W         22
`define BASE_FRAC      8
`define BASE_SHIFT     6

`define CLK_NS         100
`define REARM_NS       200
`define REARM_CYC      ((`REARM_NS + `CLK_NS - 1) / `CLK_NS)

`define ADDR_CTRL      8'h00
`define ADDR_SPAN      8'h04
`define ADDR_PRE       8'h08
`define ADDR_DELAY     8'h0C
`define ADDR_ACCUM     8'h10
`define ADDR_SKIP      8'h14
`define ADDR_PERIOD    8'h18
`define ADDR_LEVEL     8'h1C
`define ADDR_CH_BASE   8'h20
`define ADDR_CH_STRIDE 8'h08
`define ADDR_THR_OFS   8'h04
`define ADDR_STATUS    8'h30

`define CTRL_SRC_LSB   0
`define CTRL_OUTEN     2
`define CTRL_BASEEN    3
`define CTRL_SWTRIG    4

`define RST_SPAN       7'h40
`define RST_ACCUM      16'h0001
`define RST_SKIP       4'h1
`define RST_PERIOD     24'h00_0400
`define RST_LEVEL      14'h2000
`define RST_TARGET     22'h08_0000

`endif

// ==== rtl/capture_pkg.sv ====
package capture_pkg;
`include "capture_consts.svh"

   typedef enum logic [2:0] {
      ST_IDLE    = 3'h0,
      ST_DELAY   = 3'h1,
      ST_CAPTURE = 3'h2,
      ST_FLUSH   = 3'h3,
      ST_REARM   = 3'h4
   } cap_state_t;

   typedef enum logic [1:0] {
      SRC_INT   = 2'h0,
      SRC_EXT   = 2'h1,
      SRC_SW    = 2'h2,
      SRC_LEVEL = 2'h3
   } trigger_connector_src_t;

   typedef logic [`SAMPLE_W-1:0] sample_t;
   typedef logic [`SUM_W-1:0]    sum_t;

endpackage : capture_pkg

// ==== rtl/sample_mem.sv ====
`timescale 1ns/1ns
module sample_mem #(
   parameter int W  = 14,
   parameter int AW = 6
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [W-1:0]  wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [W-1:0]  rdata
);
   logic [W-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // Write-first so a zero pre-trigger read sees the sample landing now
   always_ff @(posedge clk) begin
      if (we && (waddr == raddr)) begin
         rdata <= wdata;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule : sample_mem

// ==== rtl/trigger_capture.sv ====
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ns
// What this block does
// R1 - Trigger source selectable: internal, external connector, software, level
// R2 - Internal trigger free-runs periodically from the clock by default
// R3 - Internal trigger can be driven out on the trigger connector
// R4 - External mode starts records from the trigger connector input
// R5 - Level mode triggers from the amplitude of sampled data
// R6 - Each record holds exactly the programmed capture span of samples
// R7 - Pre-trigger count starts the record that many samples earlier
// R8 - Trigger delay waits that many samples before storing begins
// R9 - Pre-trigger and delay move the start only, never the length
// R10 - After the last sample, triggers refused for a fixed rearm time
// R11 - Triggers during capture are ignored, never restart a record
// R12 - One unit per channel, lockstep, shared span and accumulation count
// R13 - Baseline target and threshold are set per channel
// R14 - Summer adds records sample by sample, never divides
// R15 - Samples below the programmed threshold are suppressed
// R16 - Baseline stabiliser holds output at a 22-bit target
// R17 - Skip stage keeps only every M-th sample
// R18 - History buffer deeper than the largest pre-trigger count
// R19 - Summer clears at sequence start, emits after the programmed count
module trigger_capture
   import capture_pkg::*;
(
   input  wire logic                          clk,
   input  wire logic                          rst_b,
   input  wire logic [7:0]                    paddr,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic [`NCH-1:0][`SAMPLE_W-1:0] sampleIn,
   input  wire logic                          trigIn,
   output logic                               trigOut,
   output logic                               trigOe,
   output logic                               recValid,
   output logic                               recLast,
   output logic      [`NCH-1:0][`SUM_W-1:0]   recData,
   output logic                               armed
);

   typedef struct packed {
      logic [`NCH-1:0][`SAMPLE_W-1:0] smp1;
      logic [`NCH-1:0][`SAMPLE_W-1:0] smp2;
      logic                           trig1;
      logic                           trig2;
      logic                           trigPrev;
      trigger_connector_src_t                      src;
      logic                           trigOutEn;
      logic                           baseEn;
      logic [`SPAN_W-1:0]             span;
      logic [`HIST_AW-1:0]            pre;
      logic [15:0]                    delay;
      logic [15:0]                    accum;
      logic [3:0]                     skip;
      logic [23:0]                    period;
      logic [`SAMPLE_W-1:0]           level;
      logic [`NCH-1:0][`BASE_W-1:0]   target;
      logic [`NCH-1:0][`SAMPLE_W-1:0] thresh;
      logic [31:0]                    prdata;
      logic                           pready;
      logic                           pslverr;
      logic                           swTrig;
      logic [`NCH-1:0][`BASE_W-1:0]   est;
      logic [`NCH-1:0][`SAMPLE_W-1:0] proc;
      logic                           keep;
      logic [3:0]                     skipCnt;
      logic                           lvlAbove;
      logic [`HIST_AW:0]              wp;
      logic [23:0]                    periodCnt;
      logic                           intTrig;
      cap_state_t                     state;
      logic [15:0]                    dlyCnt;
      logic [`SPAN_W-1:0]             idx;
      logic [`HIST_AW:0]              start;
      logic [15:0]                    recCnt;
      logic [3:0]                     rearmCnt;
      logic                           rdPend;
      logic [`SPAN_W-1:0]             rdIdx;
      logic                           trigOut;
      logic                           recValid;
      logic                           recLast;
      logic [`NCH-1:0][`SUM_W-1:0]    recData;
      logic                           armed;
   } cap_regs_t;

   cap_regs_t q;
   cap_regs_t d;

   logic [`NCH-1:0][`BASE_W-1:0]   estNext;
   logic [`NCH-1:0][`SAMPLE_W-1:0] procNext;
   logic [`NCH-1:0][`SAMPLE_W-1:0] histRd;
   logic [`NCH-1:0][`SUM_W-1:0]    accRd;
   logic [`NCH-1:0][`SUM_W-1:0]    sum;
   logic                           firstRec;
   logic                           lastRec;
   logic                           trigEvt;
   logic                           busWrite;
   logic                           busSetup;
   logic [32:0]                    rdWord;

   // Read decode: bit 32 flags a mapped address
   function automatic logic [32:0] regRead(input logic [7:0] a,
                                           input cap_regs_t r);
      logic [32:0] v;
      v = 33'h0_0000_0000;
      case (a)
         `ADDR_CTRL:   v = {1'b1, 27'h000_0000, 1'b0, r.baseEn,
                            r.trigOutEn, r.src};
         `ADDR_SPAN:   v = {1'b1, 25'h000_0000, r.span};
         `ADDR_PRE:    v = {1'b1, 26'h000_0000, r.pre};
         `ADDR_DELAY:  v = {1'b1, 16'h0000, r.delay};
         `ADDR_ACCUM:  v = {1'b1, 16'h0000, r.accum};
         `ADDR_SKIP:   v = {1'b1, 28'h000_0000, r.skip};
         `ADDR_PERIOD: v = {1'b1, 8'h00, r.period};
         `ADDR_LEVEL:  v = {1'b1, 18'h0_0000, r.level};
         `ADDR_STATUS: v = {1'b1, 8'h00, r.recCnt, r.rearmCnt,
                            r.state, (r.state == ST_IDLE)};
         default:      v = 33'h0_0000_0000;
      endcase
      for (int c = 0; c < `NCH; c++) begin
         if (a == 8'(`ADDR_CH_BASE + c * `ADDR_CH_STRIDE)) begin
            v = {1'b1, 10'h000, r.target[c]};
         end
         if (a == 8'(`ADDR_CH_BASE + c * `ADDR_CH_STRIDE + `ADDR_THR_OFS))
         begin
            v = {1'b1, 18'h0_0000, r.thresh[c]};
         end
      end
      return v;
   endfunction : regRead

   // A count of zero or one both mean a single record per sequence
   function automatic logic isLastRec(input logic [15:0] cnt,
                                      input logic [15:0] n);
      return (n <= 16'h0001) || (cnt == n - 16'h0001);
   endfunction : isLastRec

   assign firstRec = (q.recCnt == 16'h0000); // R19
   assign lastRec  = isLastRec(q.recCnt, q.accum); // R19

   // Per-channel data path and memories
   genvar gc;
   generate
      for (gc = 0; gc < `NCH; gc++) begin : g_ch // R12
         logic signed [22:0] rawFx;
         logic signed [22:0] diff;
         logic signed [16:0] shifted;
         logic        [13:0] sat;

         assign rawFx = {1'b0, q.smp2[gc], 8'h00};
         assign diff  = rawFx - {1'b0, q.est[gc]};
         // Slow leaky tracker keeps pulses from dragging the baseline
         assign estNext[gc] = q.est[gc] +
                              22'(diff >>> `BASE_SHIFT); // R16
         assign shifted = {3'h0, q.smp2[gc]}
                        + {3'h0, q.target[gc][`BASE_W-1:`BASE_FRAC]}
                        - {3'h0, q.est[gc][`BASE_W-1:`BASE_FRAC]}; // R16
         assign sat = (!q.baseEn) ? q.smp2[gc] :
                      (shifted < 0) ? 14'h0000 :
                      (shifted > 17'sh0_3FFF) ? 14'h3FFF :
                      shifted[13:0];
         assign procNext[gc] = (sat < q.thresh[gc]) ? 14'h0000
                                                    : sat; // R13 R15

         // Twice the largest pre-trigger so a full-depth lag never
         // collides with the sample being written
         sample_mem #(.W(`SAMPLE_W), .AW(`HIST_AW + 1)) u_hist ( // R18
            .clk   (clk),
            .we    (q.keep),
            .waddr (q.wp),
            .wdata (q.proc[gc]),
            .raddr (q.start + q.idx), // R7 R9
            .rdata (histRd[gc])
         );

         // First record of a sequence overwrites instead of adding
         assign sum[gc] = (firstRec ? 32'h0000_0000 : accRd[gc])
                        + {18'h0_0000, histRd[gc]}; // R14 R19

         sample_mem #(.W(`SUM_W), .AW(`HIST_AW)) u_sum (
            .clk   (clk),
            .we    (q.rdPend),
            .waddr (q.rdIdx[`HIST_AW-1:0]),
            .wdata (sum[gc]),
            .raddr (q.idx[`HIST_AW-1:0]),
            .rdata (accRd[gc])
         );
      end
   endgenerate

   always_comb begin
      d = q;
      rdWord   = regRead(paddr, q);
      busSetup = psel & ~penable & ~q.pready;
      busWrite = psel & penable & q.pready & pwrite;

      d.smp1  = sampleIn;
      d.smp2  = q.smp1;
      d.trig1 = trigIn;
      d.trig2 = q.trig1;
      d.trigPrev = q.trig2;

      // APB: ready in the first cycle of the access phase, no wait states
      d.pready  = busSetup;
      d.pslverr = busSetup & ~rdWord[32];
      if (busSetup) begin
         d.prdata = pwrite ? 32'h0000_0000 : rdWord[31:0];
      end
      d.swTrig = 1'b0;
      if (busWrite) begin
         case (paddr)
            `ADDR_CTRL: begin
               d.src       = trigger_connector_src_t'(pwdata[`CTRL_SRC_LSB +: 2]); // R1
               d.trigOutEn = pwdata[`CTRL_OUTEN];
               d.baseEn    = pwdata[`CTRL_BASEEN];
               d.swTrig    = pwdata[`CTRL_SWTRIG];
            end
            `ADDR_SPAN:   d.span   = pwdata[`SPAN_W-1:0];
            `ADDR_PRE:    d.pre    = pwdata[`HIST_AW-1:0];
            `ADDR_DELAY:  d.delay  = pwdata[15:0];
            `ADDR_ACCUM:  d.accum  = pwdata[15:0];
            `ADDR_SKIP:   d.skip   = pwdata[3:0];
            `ADDR_PERIOD: d.period = pwdata[23:0];
            `ADDR_LEVEL:  d.level  = pwdata[`SAMPLE_W-1:0];
            default: ;
         endcase
         for (int c = 0; c < `NCH; c++) begin
            if (paddr == 8'(`ADDR_CH_BASE + c * `ADDR_CH_STRIDE)) begin
               d.target[c] = pwdata[`BASE_W-1:0]; // R13
            end
            if (paddr == 8'(`ADDR_CH_BASE + c * `ADDR_CH_STRIDE
                            + `ADDR_THR_OFS)) begin
               d.thresh[c] = pwdata[`SAMPLE_W-1:0]; // R13
            end
         end
      end

      // Conditioning stages run on every converter sample
      for (int c = 0; c < `NCH; c++) begin
         d.est[c]  = estNext[c];
         d.proc[c] = procNext[c];
      end
      d.keep = (q.skipCnt == 4'h0); // R17
      if ((q.skip <= 4'h1) || (q.skipCnt >= q.skip - 4'h1)) begin
         d.skipCnt = 4'h0; // R17
      end else begin
         d.skipCnt = q.skipCnt + 4'h1;
      end
      if (q.keep) begin
         d.wp = q.wp + 7'h01;
      end

      // Free-running period generator
      d.intTrig = 1'b0;
      if ((q.period <= 24'h00_0001) ||
          (q.periodCnt >= q.period - 24'h00_0001)) begin
         d.periodCnt = 24'h00_0000;
         d.intTrig   = 1'b1; // R2
      end else begin
         d.periodCnt = q.periodCnt + 24'h00_0001;
      end
      d.trigOut = d.intTrig & q.trigOutEn; // R3

      d.lvlAbove = q.keep ? (q.proc[0] >= q.level) : q.lvlAbove;
      case (q.src)
         SRC_INT:   trigEvt = q.intTrig; // R1
         SRC_EXT:   trigEvt = q.trig2 & ~q.trigPrev; // R4
         SRC_SW:    trigEvt = q.swTrig;
         SRC_LEVEL: trigEvt = q.keep & (q.proc[0] >= q.level)
                              & ~q.lvlAbove; // R5
         default:   trigEvt = 1'b0;
      endcase

      d.rdPend   = 1'b0;
      d.recValid = 1'b0;
      d.recLast  = 1'b0;
      case (q.state)
         ST_IDLE: begin
            d.idx = 7'h00;
            if (trigEvt) begin
               if (q.delay == 16'h0000) begin
                  d.start = q.wp - {1'b0, q.pre}; // R7
                  d.state = ST_CAPTURE;
               end else begin
                  d.dlyCnt = q.delay;
                  d.state  = ST_DELAY; // R8
               end
            end
         end
         ST_DELAY: begin
            if (q.keep) begin
               d.dlyCnt = q.dlyCnt - 16'h0001; // R8
               if (q.dlyCnt == 16'h0001) begin
                  d.start = q.wp - {1'b0, q.pre}; // R7 R8 R9
                  d.state = ST_CAPTURE;
               end
            end
         end
         ST_CAPTURE: begin
            // Triggers are not looked at here
            if (q.keep) begin // R11
               d.rdPend = 1'b1;
               d.rdIdx  = q.idx;
               d.idx    = q.idx + 7'h01;
               if (q.idx >= q.span - 7'h01) begin
                  d.state = ST_FLUSH; // R6 R9
               end
            end
         end
         ST_FLUSH: begin
            d.recCnt   = lastRec ? 16'h0000 : q.recCnt + 16'h0001; // R19
            d.rearmCnt = 4'(`REARM_CYC - 1);
            d.state    = ST_REARM;
         end
         ST_REARM: begin
            // Fixed refusal window before rearming
            if (q.rearmCnt == 4'h0) begin
               d.state = ST_IDLE; // R10
            end else begin
               d.rearmCnt = q.rearmCnt - 4'h1;
            end
         end
         default: d.state = ST_IDLE;
      endcase

      if (q.rdPend && lastRec) begin
         d.recValid = 1'b1; // R19
         d.recLast  = (q.rdIdx >= q.span - 7'h01);
         d.recData  = sum; // R14
      end

      if (!rst_b) begin
         d           = '0;
         d.src       = SRC_INT; // R2
         d.span      = `RST_SPAN;
         d.accum     = `RST_ACCUM;
         d.skip      = `RST_SKIP;
         d.period    = `RST_PERIOD;
         d.level     = `RST_LEVEL;
         d.baseEn    = 1'b1;
         d.state     = ST_IDLE;
         for (int c = 0; c < `NCH; c++) begin
            d.target[c] = `RST_TARGET;
         end
      end
      d.armed = (d.state == ST_IDLE);
   end

   always_ff @(posedge clk) begin
      q <= d;
   end

   assign prdata   = q.prdata;
   assign pready   = q.pready;
   assign pslverr  = q.pslverr;
   assign trigOut  = q.trigOut;
   assign trigOe   = q.trigOutEn;
   assign recValid = q.recValid;
   assign recLast  = q.recLast;
   assign recData  = q.recData;
   assign armed    = q.armed;

endmodule : trigger_capture

// ==== bench/capture_asserts.sv ====
`timescale 1ns/1ns
module cap_checker (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic        trigOut,
   input  wire logic        trigOe,
   input  wire logic        recValid,
   input  wire logic        recLast,
   input  wire logic        armed
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   setup_answered_a: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   ready_single_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   refused_reads_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
      else $error("refused read not zero");
   upper_bits_zero_a: assert property (pready && !pwrite |-> prdata[31:24] == 8'h00)
      else $error("read data upper byte set");
   drive_needs_enable_a: assert property (trigOut |-> trigOe)
      else $error("trigger driven while not enabled");
   last_with_valid_a: assert property (recLast |-> recValid)
      else $error("recLast without recValid");
   busy_while_output_a: assert property (recValid |-> !armed)
      else $error("armed during record output");
   accept_holds_off_a: assert property ($fell(armed) |-> !armed [*3])
      else $error("rearmed too soon after trigger");
   rearm_gap_a: assert property ($rose(armed) |-> !$past(armed, 2) && !$past(armed, 3))
      else $error("rearm interval too short");
endmodule : cap_checker

bind trigger_capture cap_checker cap_checker_i (
   .clk      (clk),
   .rst_b    (rst_b),
   .psel     (psel),
   .penable  (penable),
   .pwrite   (pwrite),
   .prdata   (prdata),
   .pready   (pready),
   .pslverr  (pslverr),
   .trigOut  (trigOut),
   .trigOe   (trigOe),
   .recValid (recValid),
   .recLast  (recLast),
   .armed    (armed)
);

// ==== bench/frontend_model.sv ====
`timescale 1ns/1ns
`include "capture_consts.svh"
module frontend_model (
   input  wire logic                           clk,
   input  wire logic                           ramp,
   input  wire logic [`SAMPLE_W-1:0]           lvl0,
   input  wire logic [`SAMPLE_W-1:0]           lvl1,
   input  wire logic                           extReq,
   output logic      [`NCH-1:0][`SAMPLE_W-1:0] sampleIn,
   output logic                                trigIn
);
   logic [`SAMPLE_W-1:0] cnt = '0;
   logic [1:0]           hold = 2'h0;

   initial sampleIn = '0;
   initial trigIn = 1'b0;
   // Converter delivers a fresh sample every clock, never idles
   always @(posedge clk) begin
      cnt <= cnt + 1'b1;
      sampleIn[0] <= ramp ? cnt : lvl0;
      sampleIn[1] <= ramp ? cnt + 14'h0100 : lvl1;
      // Held three clocks so the input synchroniser cannot miss it
      hold <= extReq ? 2'h2 : (hold != 2'h0 ? hold - 1'b1 : hold);
      trigIn <= extReq || hold != 2'h0;
   end
endmodule : frontend_model

// ==== bench/tb.sv ====
`timescale 1ns/1ns
`include "capture_consts.svh"
module tb import capture_pkg::*; ;
   logic                           clk = 0, rst_b = 0, psel = 0;
   logic                           penable = 0, pwrite = 0;
   logic                           ramp = 0, extReq = 0, errv;
   logic [7:0]                     paddr = 8'h00;
   logic [31:0]                    pwdata = 32'h0000_0000;
   logic [31:0]                    prdata, rdv, ctrl, exp0, exp1;
   logic                           pready, pslverr, trigIn, trigOut;
   logic                           trigOe, recValid, recLast, armed;
   logic [`NCH-1:0][`SAMPLE_W-1:0] sampleIn;
   logic [`NCH-1:0][`SUM_W-1:0]    recData;
   logic [13:0]                    lvl0 = 0, lvl1 = 0, s0, firstV, prevV;
   logic [13:0]                    step, offs, base, v0, v1;
   logic                           chkConst = 0, chkStep = 0;
   logic [31:0]                    seed = 32'h0527_4fc6;
   int                             failures = 0, nCompared = 0;
   int                             cyc = 0, nRec = 0, n;
   logic [7:0]  rA [12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
                            8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C};
   logic [31:0] rV [12] = '{32'h0000_0008, 32'h0000_0040, 32'h0000_0000,
      32'h0000_0000, 32'h0000_0001, 32'h0000_0001, 32'h0000_0400,
      32'h0000_2000, 32'h0008_0000, 32'h0000_0000, 32'h0008_0000,
      32'h0000_0000};
   logic [7:0]  wA [5] = '{8'h0C, 8'h18, 8'h1C, 8'h20, 8'h2C};
   logic [31:0] wM [5] = '{32'h0000_FFFF, 32'h00FF_FFFF, 32'h0000_3FFF,
                           32'h003F_FFFF, 32'h0000_3FFF};
   int preT [5] = '{0, 5, 0, 63, 0};
   int delT [5] = '{0, 0, 7, 0, 0};
   int skT  [5] = '{1, 1, 1, 1, 3};
   int spT  [5] = '{16, 16, 16, 64, 10};

   trigger_capture trigger_capture_i (.clk(clk), .rst_b(rst_b),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sampleIn(sampleIn), .trigIn(trigIn), .trigOut(trigOut),
      .trigOe(trigOe), .recValid(recValid), .recLast(recLast),
      .recData(recData), .armed(armed));
   frontend_model frontend_model_i (.clk(clk), .ramp(ramp), .lvl0(lvl0),
      .lvl1(lvl1), .extReq(extReq), .sampleIn(sampleIn), .trigIn(trigIn));

   always #50 clk = ~clk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [31:0] exp_sum(input logic [13:0] v, t,
                                           input int k);
      return (v < t) ? 32'h0000_0000 : 32'(v) * k;
   endfunction : exp_sum

   task automatic summarize;
      if (failures == 0 && nCompared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      nCompared++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Hang guard well above the longest expected run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         failures++;
         summarize();
      end
   end
   always @(posedge clk) if (recValid === 1'b1) begin
      if (nRec == 0) firstV <= recData[0][13:0];
      else if (chkStep) check(14'(recData[0][13:0] - prevV), step);
      prevV <= recData[0][13:0];
      if (chkConst) check(recData, {exp1, exp0});
      nRec++;
   end

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1, a, d);
   endtask : wr
   task automatic cfg(input int sp, pr, dl, ac, sk);
      wr(`ADDR_SPAN, sp);
      wr(`ADDR_PRE, pr);
      wr(`ADDR_DELAY, dl);
      wr(`ADDR_ACCUM, ac);
      wr(`ADDR_SKIP, sk);
   endtask : cfg
   task automatic do_reset;
      rst_b <= 0;
      repeat (4) @(posedge clk);
      rst_b <= 1;
   endtask : do_reset
   task automatic run(input trigger_connector_src_t src, input int nTrig, input bit extra);
      int k;
      nRec = 0;
      for (int i = 0; i < nTrig; i++) begin
         k = 0;
         while (armed !== 1'b1 && k < 3000) begin
            @(posedge clk);
            k++;
         end
         if (k >= 3000) failures++;
         if (src == SRC_SW) begin
            wr(`ADDR_CTRL, ctrl | 32'h0000_0010);
            s0 = sampleIn[0];
         end else if (src == SRC_EXT) begin
            extReq <= 1;
            @(posedge clk);
            extReq <= 0;
         end
         repeat (6) @(posedge clk);
      end
      if (extra) wr(`ADDR_CTRL, ctrl | 32'h0000_0010);
      k = 0;
      while (recLast !== 1'b1 && k < 3000) begin
         @(posedge clk);
         k++;
      end
      if (k >= 3000) failures++;
      repeat (40) @(posedge clk);
   endtask : run

   initial begin
      do_reset();
      for (int i = 0; i < 12; i++) begin
         apb(0, rA[i], 0);
         check({errv, rdv}, {1'b0, rV[i]});
      end
      apb(0, `ADDR_STATUS, 0);
      check(rdv[0], 1'b1);
      apb(0, 8'h40, 0);
      check({errv, rdv}, {1'b1, 32'h0000_0000});
      for (int i = 0; i < 5; i++) begin
         seed = lfsr(seed);
         wr(wA[i], seed);
         apb(0, wA[i], 0);
         check(rdv, seed & wM[i]);
      end
      ctrl = 32'h0000_0002;
      wr(`ADDR_CTRL, ctrl);
      wr(8'h20, `RST_TARGET);
      wr(8'h28, `RST_TARGET);
      seed = lfsr(seed);
      v0 = {2'b01, seed[11:0]};
      v1 = {2'b00, seed[23:12]};
      lvl0 <= v0;
      lvl1 <= v1;
      // Accumulation, per-channel thresholds, then a fresh sequence
      wr(8'h24, 32'h0000_1000);
      wr(8'h2C, 32'h0000_1000);
      cfg(8, 0, 0, 3, 1);
      exp0 = exp_sum(v0, 14'h1000, 3);
      exp1 = exp_sum(v1, 14'h1000, 3);
      chkConst = 1;
      run(SRC_SW, 3, 0);
      check(nRec, 8);
      wr(8'h24, 32'h0000_3FFF);
      wr(8'h2C, 32'h0000_0000);
      wr(`ADDR_ACCUM, 2);
      exp0 = exp_sum(v0, 14'h3FFF, 2);
      exp1 = exp_sum(v1, 14'h0000, 2);
      run(SRC_SW, 2, 0);
      check(nRec, 8);
      chkConst = 0;
      // Record position and length with a ramp on the input
      wr(8'h24, 32'h0000_0000);
      ramp <= 1;
      chkStep = 1;
      for (int i = 0; i < 5; i++) begin
         step = skT[i];
         cfg(spT[i], preT[i], delT[i], 1, skT[i]);
         run(SRC_SW, 1, i == 0);
         check(nRec, spT[i]);
         offs = 14'(firstV - s0);
         if (i == 0) base = offs;
         else if (skT[i] == 1) check(offs, 14'(base - preT[i] + delT[i]));
      end
      chkStep = 0;
      ramp <= 0;
      cfg(4, 0, 0, 1, 1);
      ctrl = 32'h0000_0001;
      wr(`ADDR_CTRL, ctrl);
      run(SRC_EXT, 1, 0);
      check(nRec, 4);
      lvl0 <= 14'h0800;
      wr(`ADDR_LEVEL, 32'h0000_1000);
      ctrl = 32'h0000_0003;
      wr(`ADDR_CTRL, ctrl);
      nRec = 0;
      repeat (50) @(posedge clk);
      check(nRec, 0);
      lvl0 <= 14'h1800;
      run(SRC_LEVEL, 1, 0);
      check(nRec, 4);
      wr(`ADDR_PERIOD, 40);
      ctrl = 32'h0000_0004;
      wr(`ADDR_CTRL, ctrl);
      n = 0;
      while (trigOut !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (trigOut !== 1'b1 && n < 200);
      check(n, 40);
      check(trigOe, 1'b1);
      do_reset();
      apb(0, `ADDR_CTRL, 0);
      check(rdv, 32'h0000_0008);
      summarize();
   end
endmodule : tb
